// *** core/pce_pin_change.sv ***
// pin change interrupt: edge enables, pin flags, summary and interrupt outputs
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ps
module pce_pin_change #(
	parameter int NUM_PORTS = pce_pkg::NUM_PORTS_DEF,
	parameter int PORT_W    = pce_pkg::PORT_W_DEF
) (
	// clock, reset, enable
	input  wire logic                        clk_in,
	input  wire logic                        sys_rst_in,
	input  wire logic                        ce_in,
	// port pins, port p at bits p*PORT_W upward
	input  wire logic [NUM_PORTS*PORT_W-1:0] pins_in,
	// processor state
	input  wire logic                        sleep_in,
	// register port
	input  wire logic [pce_pkg::ADDR_W-1:0]  addr_in,
	input  wire logic [pce_pkg::DATA_W-1:0]  wr_data_in,
	input  wire logic                        wr_in,
	input  wire logic                        rd_in,
	output logic      [pce_pkg::DATA_W-1:0]  rd_data_out,
	// interrupt and wake outputs
	output logic                             chg_irq_out,
	output logic                             summary_flag_out,
	output logic                             irq_out,
	output logic                             wake_out
);
	import pce_pkg::*;

	// parameters that the address map or data path cannot hold
	if (NUM_PORTS < 1 || NUM_PORTS > MAX_PORTS) begin : g_chk_ports
		$error("NUM_PORTS out of range");
	end
	if (PORT_W < 1 || PORT_W > DATA_W) begin : g_chk_width
		$error("PORT_W out of range");
	end

	// per-port state
	logic [PORT_W-1:0]  rise_en_r  [NUM_PORTS];
	logic [PORT_W-1:0]  fall_en_r  [NUM_PORTS];
	logic [PORT_W-1:0]  flag_r     [NUM_PORTS];
	logic [PORT_W-1:0]  flag_nxt   [NUM_PORTS];
	logic [PORT_W-1:0]  rise_w     [NUM_PORTS];
	logic [PORT_W-1:0]  fall_w     [NUM_PORTS];
	logic [PORT_W-1:0]  level_w    [NUM_PORTS];
	logic [PORT_W-1:0]  hit_w      [NUM_PORTS];
	logic [NUM_PORTS-1:0] port_hit_w;
	logic [NUM_PORTS-1:0] port_repeat_w;

	// shared state
	logic                 master_en_r;
	logic [EV_W-1:0]      ev_stat_r;
	logic [EV_W-1:0]      ev_stat_nxt;
	logic [EV_W-1:0]      ev_mask_r;
	logic [EV_W-1:0]      ev_set_w;
	logic [EV_W-1:0]      ev_clr_w;
	logic                 any_hit_w;
	logic                 any_flag_nxt;
	logic                 any_flag_w;
	logic [DATA_W-1:0]    rd_data_nxt;
	logic [DATA_W-1:0]    rd_data_r;
	logic                 chg_irq_r;
	logic                 summary_r;
	logic                 irq_r;
	logic                 wake_r;

	// decoded shared writes
	logic                 wr_ctrl_w;
	logic                 wr_stat_w;
	logic                 wr_mask_w;

	assign wr_ctrl_w = ce_in && wr_in && (addr_in == ADDR_INT_CTRL);
	assign wr_stat_w = ce_in && wr_in && (addr_in == ADDR_IRQ_STAT);
	assign wr_mask_w = ce_in && wr_in && (addr_in == ADDR_IRQ_MASK);

	for (genvar gp = 0; gp < NUM_PORTS; gp++) begin : g_port
		localparam logic [ADDR_W-1:0] A_RISE = ADDR_RISE_BASE + ADDR_W'(gp);
		localparam logic [ADDR_W-1:0] A_FALL = ADDR_FALL_BASE + ADDR_W'(gp);
		localparam logic [ADDR_W-1:0] A_FLAG = ADDR_FLAG_BASE + ADDR_W'(gp);

		logic wr_rise_w;
		logic wr_fall_w;
		logic wr_flag_w;

		assign wr_rise_w = ce_in && wr_in && (addr_in == A_RISE);
		assign wr_fall_w = ce_in && wr_in && (addr_in == A_FALL);
		assign wr_flag_w = ce_in && wr_in && (addr_in == A_FLAG);

		pce_edge_det #(
			.W (PORT_W)
		) u_det (
			.clk_in     (clk_in),
			.sys_rst_in (sys_rst_in),
			.ce_in      (ce_in),
			.pins_in    (pins_in[gp*PORT_W +: PORT_W]),
			.rise_out   (rise_w[gp]),
			.fall_out   (fall_w[gp]),
			.level_out  (level_w[gp])
		);

		// rising edge enables, one bit per pin
		always_ff @(posedge clk_in) begin
			if (sys_rst_in) begin
				rise_en_r[gp] <= RST_ENABLE[PORT_W-1:0];
			end else if (wr_rise_w) begin
				rise_en_r[gp] <= wr_data_in[PORT_W-1:0];
			end
		end

		// falling edge enables, one bit per pin
		always_ff @(posedge clk_in) begin
			if (sys_rst_in) begin
				fall_en_r[gp] <= RST_ENABLE[PORT_W-1:0];
			end else if (wr_fall_w) begin
				fall_en_r[gp] <= wr_data_in[PORT_W-1:0];
			end
		end

		// armed detections; both polarities may be armed at once
		assign hit_w[gp] = (rise_w[gp] & rise_en_r[gp])
			| (fall_w[gp] & fall_en_r[gp]);

		// a write stores its value, but a fresh hit always wins, so a
		// clearing write cannot swallow an edge that lands with it
		always_comb begin
			flag_nxt[gp] = flag_r[gp];
			if (wr_flag_w) begin
				flag_nxt[gp] = wr_data_in[PORT_W-1:0];
			end
			flag_nxt[gp] = flag_nxt[gp] | hit_w[gp];
		end

		always_ff @(posedge clk_in) begin
			if (sys_rst_in) begin
				flag_r[gp] <= RST_FLAG[PORT_W-1:0];
			end else if (ce_in) begin
				flag_r[gp] <= flag_nxt[gp];
			end
		end

		assign port_hit_w[gp]    = |hit_w[gp];
		// an edge on a pin whose flag is still pending
		assign port_repeat_w[gp] = |(hit_w[gp] & flag_r[gp]);
	end

	// summary of every flag, both the stored and the next value
	always_comb begin
		any_flag_nxt = 1'b0;
		any_flag_w   = 1'b0;
		for (int p = 0; p < NUM_PORTS; p++) begin
			any_flag_nxt = any_flag_nxt | (|flag_nxt[p]);
			any_flag_w   = any_flag_w | (|flag_r[p]);
		end
	end

	assign any_hit_w = |port_hit_w;

	// master change interrupt enable
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			master_en_r <= RST_MASTER;
		end else if (wr_ctrl_w) begin
			master_en_r <= wr_data_in[BIT_MASTER_EN];
		end
	end

	// summary flag output tracks the flags in the same cycle
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			summary_r <= 1'b0;
		end else if (ce_in) begin
			summary_r <= any_flag_nxt;
		end
	end

	// change request: flags keep setting, only the request is gated
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			chg_irq_r <= 1'b0;
		end else if (ce_in) begin
			chg_irq_r <= any_flag_nxt & master_en_r;
		end
	end

	// wake holds while asleep once an armed edge arrived with master set;
	// it falls with sleep_in so a second sleep needs a new edge
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			wake_r <= 1'b0;
		end else if (ce_in) begin
			if (!sleep_in) begin
				wake_r <= 1'b0;
			end else if (any_hit_w && master_en_r) begin
				wake_r <= 1'b1;
			end
		end
	end

	// event status: sticky, write one to clear, a new event wins
	assign ev_set_w[BIT_EV_EDGE]   = any_hit_w;
	assign ev_set_w[BIT_EV_WAKE]   = any_hit_w & master_en_r & sleep_in;
	assign ev_set_w[BIT_EV_REPEAT] = |port_repeat_w;
	assign ev_clr_w = wr_stat_w ? wr_data_in[EV_W-1:0] : '0;
	assign ev_stat_nxt = (ev_stat_r & ~ev_clr_w) | ev_set_w;

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			ev_stat_r <= RST_EV;
		end else if (ce_in) begin
			ev_stat_r <= ev_stat_nxt;
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			ev_mask_r <= RST_EV;
		end else if (wr_mask_w) begin
			ev_mask_r <= wr_data_in[EV_W-1:0];
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			irq_r <= 1'b0;
		end else if (ce_in) begin
			irq_r <= |(ev_stat_nxt & ev_mask_r);
		end
	end

	// read decode; unmapped addresses read zero
	always_comb begin
		rd_data_nxt = '0;
		if (addr_in == ADDR_INT_CTRL) begin
			rd_data_nxt[BIT_SUMMARY]   = any_flag_w;
			rd_data_nxt[BIT_MASTER_EN] = master_en_r;
		end else if (addr_in == ADDR_IRQ_STAT) begin
			rd_data_nxt = DATA_W'(ev_stat_r);
		end else if (addr_in == ADDR_IRQ_MASK) begin
			rd_data_nxt = DATA_W'(ev_mask_r);
		end else begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				if (addr_in == ADDR_RISE_BASE + ADDR_W'(p)) begin
					rd_data_nxt = DATA_W'(rise_en_r[p]);
				end else if (addr_in == ADDR_FALL_BASE + ADDR_W'(p)) begin
					rd_data_nxt = DATA_W'(fall_en_r[p]);
				end else if (addr_in == ADDR_FLAG_BASE + ADDR_W'(p)) begin
					rd_data_nxt = DATA_W'(flag_r[p]);
				end else if (addr_in == ADDR_LEVEL_BASE + ADDR_W'(p)) begin
					rd_data_nxt = DATA_W'(level_w[p]);
				end
			end
		end
	end

	// read data stands in the cycle after a strobe taken with ce_in high, and holds while ce_in is low
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			rd_data_r <= '0;
		end else if (ce_in) begin
			rd_data_r <= rd_in ? rd_data_nxt : '0;
		end
	end

	assign rd_data_out      = rd_data_r;
	assign chg_irq_out      = chg_irq_r;
	assign summary_flag_out = summary_r;
	assign irq_out          = irq_r;
	assign wake_out         = wake_r;
endmodule // pce_pin_change

// *** core/pce_pkg.sv ***
// constants shared by the pin change interrupt block
package pce_pkg;
	localparam int ADDR_W        = 8;
	localparam int DATA_W        = 8;
	localparam int NUM_PORTS_DEF = 3;
	localparam int PORT_W_DEF    = 8;
	localparam int MAX_PORTS     = 8;

	// register offsets, one byte register per address
	localparam logic [ADDR_W-1:0] ADDR_RISE_BASE  = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_FALL_BASE  = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_FLAG_BASE  = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_LEVEL_BASE = 8'h18;
	localparam logic [ADDR_W-1:0] ADDR_INT_CTRL   = 8'h20;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT   = 8'h21;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK   = 8'h22;

	// interrupt_control_reg fields
	localparam int BIT_SUMMARY   = 0;
	localparam int BIT_MASTER_EN = 3;

	// event status / mask fields
	localparam int EV_W          = 3;
	localparam int BIT_EV_EDGE   = 0;
	localparam int BIT_EV_WAKE   = 1;
	localparam int BIT_EV_REPEAT = 2;

	// reset values
	localparam logic [DATA_W-1:0] RST_ENABLE = 8'h00;
	localparam logic [DATA_W-1:0] RST_FLAG   = 8'h00;
	localparam logic              RST_MASTER = 1'b0;
	localparam logic [EV_W-1:0]   RST_EV     = 3'h0;

	// edge detector priming depth after reset
	localparam int PRIME_STAGES = 2;
endpackage

// *** core/pce_edge_det.sv ***
// per-port synchronous rising and falling edge detector
`timescale 1ns/1ps
module pce_edge_det #(
	parameter int W = 8
) (
	// clock and control
	input  wire logic         clk_in,
	input  wire logic         sys_rst_in,
	input  wire logic         ce_in,
	// pins
	input  wire logic [W-1:0] pins_in,
	// detections, valid in the cycle after a sample
	output logic      [W-1:0] rise_out,
	output logic      [W-1:0] fall_out,
	output logic      [W-1:0] level_out
);
	import pce_pkg::*;

	logic [W-1:0]              sample_r;
	logic [W-1:0]              prev_r;
	logic [PRIME_STAGES-1:0]   primed_r;

	// sample and previous sample; one transition gives one detection
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			sample_r <= '0;
			prev_r   <= '0;
		end else if (ce_in) begin
			sample_r <= pins_in;
			prev_r   <= sample_r;
		end
	end

	// a pin high at reset release is not a rising edge: hold off until
	// both sample stages carry real pin values
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			primed_r <= '0;
		end else if (ce_in) begin
			primed_r <= {primed_r[PRIME_STAGES-2:0], 1'b1};
		end
	end

	// separate detectors for each polarity
	always_comb begin
		rise_out = '0;
		fall_out = '0;
		if (primed_r[PRIME_STAGES-1]) begin
			rise_out = sample_r & ~prev_r;
			fall_out = ~sample_r & prev_r;
		end
	end

	assign level_out = sample_r;
endmodule // pce_edge_det

// *** verif/pce_pin_change_asserts.sv ***
// concurrent checks on the pin change interrupt ports
`timescale 1ns/1ps
module pce_pin_change_asserts #(
	parameter int NUM_PORTS = 3,
	parameter int PORT_W    = 8
) (
	// clock and reset
	input wire logic                        clk_in,
	input wire logic                        sys_rst_in,
	input wire logic                        ce_in,
	// stimulus
	input wire logic [NUM_PORTS*PORT_W-1:0] pins_in,
	input wire logic                        sleep_in,
	input wire logic [pce_pkg::ADDR_W-1:0]  addr_in,
	input wire logic                        wr_in,
	input wire logic                        rd_in,
	// responses
	input wire logic [pce_pkg::DATA_W-1:0]  rd_data_out,
	input wire logic                        chg_irq_out,
	input wire logic                        summary_flag_out,
	input wire logic                        irq_out,
	input wire logic                        wake_out
);
	import pce_pkg::*;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	// a pin change needs one edge to be sampled and one more to reach the flag
	sequence s_pin_moved;
		$past(pins_in, 2) != $past(pins_in, 3);
	endsequence
	sequence s_flag_written;
		$past(wr_in) && $past(ce_in);
	endsequence
	a_chg_irq_gated: assert property (chg_irq_out |-> summary_flag_out)
		else $error("change request without a pin flag");
	a_flag_cause: assert property ($rose(summary_flag_out) |-> s_pin_moved or s_flag_written)
		else $error("pin flag set with no pin change or write");
	a_flag_sticky: assert property (summary_flag_out && !wr_in |=> summary_flag_out)
		else $error("pin flag dropped without a write");
	a_summary_read: assert property (ce_in && rd_in && addr_in == ADDR_INT_CTRL
		|=> rd_data_out[BIT_SUMMARY] == $past(summary_flag_out))
		else $error("summary bit read differs from summary output");
	a_wake_asleep: assert property (wake_out |-> $past(sleep_in))
		else $error("wake request while processor awake");
	a_wake_flagged: assert property ($rose(wake_out) |-> summary_flag_out)
		else $error("wake request before pin flag");
	a_read_idle: assert property ($past(ce_in) && !$past(rd_in) |-> rd_data_out == '0)
		else $error("read data outside the read cycle");
	a_reset_quiet: assert property ($fell(sys_rst_in)
		|-> !(chg_irq_out || summary_flag_out || irq_out || wake_out))
		else $error("outputs not cleared by reset");
endmodule // pce_pin_change_asserts

bind pce_pin_change pce_pin_change_asserts #(.NUM_PORTS(NUM_PORTS), .PORT_W(PORT_W)) u_chk (
	.clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in), .pins_in(pins_in),
	.sleep_in(sleep_in), .addr_in(addr_in), .wr_in(wr_in), .rd_in(rd_in),
	.rd_data_out(rd_data_out), .chg_irq_out(chg_irq_out),
	.summary_flag_out(summary_flag_out), .irq_out(irq_out), .wake_out(wake_out));

// *** verif/pce_pins_model.sv ***
// far side model: port pin drivers and a sleeping processor
`timescale 1ns/1ps
module pce_pins_model #(
	parameter int W = 24
) (
	// clock
	input  wire logic         clk_in,
	// bench requests
	input  wire logic [W-1:0] pat_in,
	input  wire logic         sleep_req_in,
	// device side
	input  wire logic         wake_in,
	output logic      [W-1:0] pins_out,
	output logic              sleep_out
);
	initial begin
		pins_out = '0;
		sleep_out = 1'b0;
	end
	// pins move on the clock edge itself, just after the device has sampled them on that edge
	always @(posedge clk_in) begin
		pins_out <= pat_in;
	end
	// processor stays asleep until the device asks it to wake
	always @(posedge clk_in) begin
		if (wake_in)
			sleep_out <= 1'b0;
		else if (sleep_req_in)
			sleep_out <= 1'b1;
	end
endmodule // pce_pins_model

// *** verif/tb_pce_pin_change.sv ***
// self-checking bench for the pin change interrupt block
`timescale 1ns/1ps
module tb_pce_pin_change;
	import pce_pkg::*;
	localparam int NP = 2;
	// six pins a port so the unused top bits must read back as zero
	localparam int PW = 6;
	typedef struct {
		logic [ADDR_W-1:0] port;
		logic [DATA_W-1:0] rise, fall, p_a, p_b, flag;
	} pce_row_t;
	pce_row_t rows [5] = '{
		'{8'h00, 8'hFF, 8'h00, 8'h00, 8'h2A, 8'h2A},
		'{8'h00, 8'h00, 8'h3F, 8'h3F, 8'h15, 8'h2A},
		'{8'h01, 8'h0F, 8'h30, 8'h0C, 8'h33, 8'h03},
		'{8'h01, 8'h3F, 8'hFF, 8'h05, 8'h3A, 8'h3F},
		'{8'h00, 8'h00, 8'h00, 8'h00, 8'h3F, 8'h00}};
	logic [ADDR_W-1:0] zaddr [6] = '{ADDR_RISE_BASE, ADDR_FALL_BASE + 8'h01, ADDR_FLAG_BASE,
		ADDR_INT_CTRL, ADDR_IRQ_MASK, 8'h30};
	logic              clk_in, sys_rst_in, wr_in, rd_in, sleep_req, sleep, ce;
	logic              chg_irq_out, summary_flag_out, irq_out, wake_out;
	logic [ADDR_W-1:0] addr_in;
	logic [DATA_W-1:0] wr_data_in, rd_data_out, d, obs;
	logic [NP*PW-1:0]  pat, pins;
	int                failures, n_checks, n;
	pce_row_t          r;

	pce_pin_change #(.NUM_PORTS(NP), .PORT_W(PW)) dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
		.ce_in(ce), .pins_in(pins), .sleep_in(sleep), .addr_in(addr_in),
		.wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
		.chg_irq_out(chg_irq_out), .summary_flag_out(summary_flag_out), .irq_out(irq_out),
		.wake_out(wake_out));
	pce_pins_model #(.W(NP*PW)) u_far (.clk_in(clk_in), .pat_in(pat), .sleep_req_in(sleep_req),
		.wake_in(wake_out), .pins_out(pins), .sleep_out(sleep));

	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end

	task automatic tick(input int k);
		repeat (k) @(posedge clk_in);
	endtask
	task automatic chk(input string what, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
		@(posedge clk_in);
		addr_in <= a;
		wr_data_in <= v;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		@(negedge clk_in);
		v = rd_data_out;
	endtask
	task automatic set_pins(input logic [ADDR_W-1:0] p, input logic [DATA_W-1:0] v);
		@(posedge clk_in);
		pat[p*PW +: PW] <= v[PW-1:0];
	endtask
	task automatic test_done();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		sys_rst_in = 1'b1;
		{wr_in, rd_in, sleep_req} = 3'h0;
		ce = 1'b1;
		addr_in = 8'h00;
		wr_data_in = 8'h00;
		pat = '0;
		failures = 0;
		n_checks = 0;
		tick(10);
		sys_rst_in <= 1'b0;
		tick(3);
		for (int i = 0; i < 6; i++) begin
			rd_reg(zaddr[i], d);
			chk("reset value", 8'h00, d);
		end
		chk("outputs", 8'h00, {4'h0, chg_irq_out, summary_flag_out, irq_out, wake_out});
		$display("reset test done");
		for (int i = 0; i < 5; i++) begin
			r = rows[i];
			wr_reg(ADDR_RISE_BASE + r.port, r.rise);
			wr_reg(ADDR_FALL_BASE + r.port, r.fall);
			set_pins(r.port, r.p_a);
			tick(4);
			wr_reg(ADDR_FLAG_BASE + r.port, 8'h00);
			set_pins(r.port, r.p_b);
			tick(4);
			rd_reg(ADDR_RISE_BASE + r.port, d);
			chk("rise enable", r.rise & 8'h3F, d);
			rd_reg(ADDR_FLAG_BASE + r.port, d);
			chk("pin flags", r.flag, d);
			chk("summary", {7'h00, r.flag != 8'h00}, {7'h00, summary_flag_out});
			chk("change request", 8'h00, {7'h00, chg_irq_out});
			wr_reg(ADDR_FLAG_BASE + r.port, 8'h00);
			$display("row %0d done", i);
		end
		set_pins(8'h00, 8'h00);
		wr_reg(ADDR_RISE_BASE, 8'h01);
		wr_reg(ADDR_INT_CTRL, 8'h08);
		set_pins(8'h00, 8'h01);
		tick(3);
		@(negedge clk_in);
		chk("change request", 8'h01, {7'h00, chg_irq_out});
		chk("masked irq", 8'h00, {7'h00, irq_out});
		wr_reg(ADDR_IRQ_MASK, 8'h01);
		tick(1);
		@(negedge clk_in);
		chk("unmasked irq", 8'h01, {7'h00, irq_out});
		rd_reg(ADDR_IRQ_STAT, d);
		chk("event status", 8'h01, d);
		wr_reg(ADDR_IRQ_STAT, 8'h01);
		wr_reg(ADDR_FLAG_BASE, 8'h00);
		tick(1);
		@(negedge clk_in);
		chk("cleared irqs", 8'h00, {6'h00, chg_irq_out, irq_out});
		wr_reg(ADDR_INT_CTRL, 8'h00);
		$display("interrupt test done");
		wr_reg(ADDR_RISE_BASE, 8'h03);
		set_pins(8'h00, 8'h00);
		set_pins(8'h00, 8'h01);
		tick(3);
		rd_reg(ADDR_FLAG_BASE, obs);
		// software re-reads the flags and writes them back with the observed bits masked out;
		// the edge on pin 1 lands on the same edge as that clearing write
		rd_reg(ADDR_FLAG_BASE, d);
		set_pins(8'h00, 8'h03);
		tick(1);
		wr_reg(ADDR_FLAG_BASE, d & ~obs);
		tick(1);
		rd_reg(ADDR_FLAG_BASE, d);
		chk("flag during clear", 8'h02, d);
		wr_reg(ADDR_FLAG_BASE, 8'h00);
		$display("clear race test done");
		set_pins(8'h00, 8'h00);
		sleep_req <= 1'b1;
		tick(1);
		sleep_req <= 1'b0;
		set_pins(8'h00, 8'h01);
		tick(4);
		@(negedge clk_in);
		chk("wake without master", 8'h01, {6'h00, wake_out, summary_flag_out});
		wr_reg(ADDR_FLAG_BASE, 8'h00);
		set_pins(8'h00, 8'h00);
		wr_reg(ADDR_INT_CTRL, 8'h08);
		set_pins(8'h00, 8'h01);
		n = 0;
		while (wake_out !== 1'b1 && n < 8) begin
			@(negedge clk_in);
			n++;
		end
		chk("wake and flag", 8'h03, {6'h00, wake_out, summary_flag_out});
		if (n == 8)
			test_done();
		tick(3);
		@(negedge clk_in);
		chk("wake released", 8'h00, {7'h00, wake_out});
		rd_reg(ADDR_IRQ_STAT, d);
		chk("wake event", 8'h03, d);
		rd_reg(ADDR_LEVEL_BASE + 8'h01, d);
		chk("pin level", 8'h3A, d);
		$display("sleep test done");
		// reset again while a flag and the interrupt are pending
		@(posedge clk_in);
		sys_rst_in <= 1'b1;
		tick(2);
		sys_rst_in <= 1'b0;
		tick(2);
		@(negedge clk_in);
		chk("reset outputs", 8'h00, {4'h0, chg_irq_out, summary_flag_out, irq_out, wake_out});
		rd_reg(ADDR_FLAG_BASE, d);
		chk("flags after reset", 8'h00, d);
		$display("second reset test done");
		// a write while the clock enable is low must not land
		@(posedge clk_in);
		ce <= 1'b0;
		wr_reg(ADDR_RISE_BASE, 8'h3F);
		@(posedge clk_in);
		ce <= 1'b1;
		rd_reg(ADDR_RISE_BASE, d);
		chk("write while frozen", 8'h00, d);
		$display("clock enable test done");
		test_done();
	end
endmodule // tb_pce_pin_change
